// ===== core/ppfc_map.vh
// Register map, codes and timing constants of the port power and fault control block
`ifndef PPFC_MAP_VH
`define PPFC_MAP_VH

// Register byte offsets
`define PPFC_REG_CMD      8'h00
`define PPFC_REG_PRST     8'h04
`define PPFC_REG_HARD_LIMIT_TIMER     8'h08
`define PPFC_REG_MODE     8'h0C
`define PPFC_REG_RSEL     8'h10
`define PPFC_REG_FOLD     8'h14
`define PPFC_REG_STAT     8'h18
`define PPFC_REG_FLTA     8'h1C
`define PPFC_REG_FLTB     8'h20
`define PPFC_REG_LIM0     8'h40
`define PPFC_LIM_BASE     2'h1

// Field positions in 32-bit words
`define PPFC_LO_LSB       0
`define PPFC_HI_LSB       16

// Hard limit codes for the 425 mA and 850 mA settings
`define PPFC_CODE_425_LRG 8'h00
`define PPFC_CODE_850_LRG 8'h40
`define PPFC_CODE_425_SML 8'h80

// Port states, one-hot
`define PPFC_ST_OFF       4'h1
`define PPFC_ST_INR       4'h2
`define PPFC_ST_ON        4'h4
`define PPFC_ST_FAIL      4'h8

// Times
`define PPFC_CLK_NS       8
`define PPFC_TICK_NS      10000
`define PPFC_OVL_US       60000
`define PPFC_HLT_US       12000
`define PPFC_INR_US       60000
`define PPFC_DMG_US       180
`define PPFC_OVL_UP       16
`define PPFC_OVL_DN       1

`endif

// ===== core/ppfc_tick.v
// Timebase divider producing a one-cycle tick enable
`timescale 1ns/1ps
module ppfc_tick #(
    parameter DIV = 1250
) (
    input  wire       clk_i,
    input  wire       rst_i,
    output wire       tick_o
);
    reg  [15:0] cnt_ff;
    wire        wrap;

    assign wrap   = (cnt_ff == DIV[15:0] - 16'h0001);
    assign tick_o = wrap;

    // Wraps every DIV cycles
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 16'h0000;
        end else if (wrap) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
endmodule // ppfc_tick

// ===== core/ppfc_fault_timer.v
// Saturating up/down fault timer with terminal flag
`timescale 1ns/1ps
module ppfc_fault_timer #(
    parameter W    = 17,
    parameter UP   = 1,
    parameter DN   = 1,
    parameter TERM = 100
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         tick_i,
    input  wire         clr_i,
    input  wire         up_i,
    input  wire         dn_i,
    output wire         exp_o
);
    reg  [W-1:0] cnt_ff;
    wire [W:0]   sum;

    assign sum   = {1'b0, cnt_ff} + UP[W:0];
    assign exp_o = (cnt_ff >= TERM[W-1:0]);

    // Up count clamps at terminal, down count saturates at zero
    always @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_ff <= {W{1'b0}};
        end else if (tick_i && up_i) begin
            cnt_ff <= (sum >= {1'b0, TERM[W-1:0]}) ? TERM[W-1:0] : sum[W-1:0];
        end else if (tick_i && dn_i) begin
            cnt_ff <= (cnt_ff > DN[W-1:0]) ? cnt_ff - DN[W-1:0] : {W{1'b0}};
        end
    end
endmodule // ppfc_fault_timer

// ===== core/ppfc_ctrl.v
// Per-port power switch control, fault timers and Wishbone register file
//
// Behaviour
// RQ1 - Turn-on ramps gate, holds at inrush limit
// RQ2 - Inrush lasts until inrush timer expires
// RQ3 - Inrush expiry over limit: off, fault
// RQ4 - Overload threshold only counts overload timer up
// RQ5 - Below threshold, overload timer counts down slower
// RQ6 - Overload timer terminal: off, overload fault
// RQ7 - Hard current limit regulation always active
// RQ8 - Hard-limit timer runs only when enabled
// RQ9 - Hard-limit timer terminal: off, hard fault
// RQ10 - Timer disabled: overload timer counts hard events
// RQ11 - Inrush uses default limit, then programmed
// RQ12 - Port off returns limit to default
// RQ13 - Host keeps 425mA unless type 2 load
// RQ14 - Limit code meaning depends on sense resistor
// RQ15 - Per-port two-stage foldback on low voltage
// RQ16 - Persistent damaged switch disables port, reports
// RQ17 - Switch failure held until port reset
// RQ18 - Open switch gives inrush timeout, not failure
// RQ19 - Semi-auto high power needs good detection
// RQ20 - Overload saturates at zero, timers clear off
// RQ21 - Fault reports latched until host clears
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ppfc_map.vh"
module ppfc_ctrl #(
    parameter NP       = 12,
    parameter GW       = 4,
    parameter TICK_CYC = `PPFC_TICK_NS / `PPFC_CLK_NS,
    parameter OVL_TERM = (`PPFC_OVL_US * 1000 / `PPFC_TICK_NS) * `PPFC_OVL_UP,
    parameter HLT_TERM = `PPFC_HLT_US * 1000 / `PPFC_TICK_NS,
    parameter INR_TERM = `PPFC_INR_US * 1000 / `PPFC_TICK_NS,
    parameter DMG_TERM = `PPFC_DMG_US * 1000 / `PPFC_TICK_NS + 1
) (
    input  wire           clk_i,
    input  wire           rst_i,
    input  wire           wb_cyc_i,
    input  wire           wb_stb_i,
    input  wire           wb_we_i,
    input  wire [7:0]     wb_adr_i,
    input  wire [3:0]     wb_sel_i,
    input  wire [31:0]    wb_dat_i,
    output reg  [31:0]    wb_dat_o,
    output wire           wb_ack_o,
    input  wire [NP-1:0]  over_inrush_i,
    input  wire [NP-1:0]  over_cut_i,
    input  wire [NP-1:0]  over_lim_i,
    input  wire [NP-1:0]  out_good_i,
    input  wire [NP-1:0]  out_present_i,
    input  wire [NP-1:0]  sense_high_i,
    input  wire [NP-1:0]  gate_high_i,
    input  wire [NP-1:0]  det_good_i,
    input  wire [NP-1:0]  volt_low1_i,
    input  wire [NP-1:0]  volt_low2_i,
    output wire [NP-1:0]  gate_en_o,
    output wire [NP*GW-1:0] gate_lvl_o,
    output wire [NP*8-1:0] hard_current_limit_code_o,
    output wire [NP*2-1:0] fold_stage_o,
    output wire [NP-1:0]  weak_pd_o
);
    // Bus handshake and write strobes
    reg             ack_ff;
    wire            req;
    wire            wr;
    wire [31:0]     wmask;
    wire [31:0]     wdat;

    // Configuration registers
    reg  [NP-1:0]   hard_limit_timer_en_ff;
    reg  [NP-1:0]   semi_ff;
    reg  [NP-1:0]   hipwr_ff;
    reg  [NP-1:0]   rsmall_ff;
    reg  [NP*2-1:0] fold_ff;
    reg  [7:0]      limit_ff [0:NP-1];

    // Per-port state and latched reports
    reg  [3:0]      st_ff [0:NP-1];
    reg  [GW-1:0]   lvl_ff [0:NP-1];
    reg  [NP-1:0]   inr_flt_ff;
    reg  [NP-1:0]   ovl_flt_ff;
    reg  [NP-1:0]   hlt_flt_ff;
    reg  [NP-1:0]   sw_fail_ff;

    // Decoded commands and timer results
    wire            tick;
    wire [NP-1:0]   cmd_on;
    wire [NP-1:0]   cmd_off;
    wire [NP-1:0]   prst;
    wire [NP-1:0]   clr_a_lo;
    wire [NP-1:0]   clr_a_hi;
    wire [NP-1:0]   clr_b;
    wire [NP-1:0]   inr_exp;
    wire [NP-1:0]   ovl_exp;
    wire [NP-1:0]   hlt_exp;
    wire [NP-1:0]   dmg_exp;
    wire [NP-1:0]   pwr;
    wire            lim_hit;
    wire [3:0]      lim_idx;
    reg  [31:0]     nxt_rdat;
    integer         p;

    // Registered ack: one wait state, one-cycle pulse
    assign req      = wb_cyc_i & wb_stb_i;
    assign wr       = req & wb_we_i & ack_ff;
    assign wb_ack_o = ack_ff;
    assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat     = wb_dat_i & wmask;
    assign lim_idx  = wb_adr_i[5:2];
    assign lim_hit  = (wb_adr_i[7:6] == `PPFC_LIM_BASE) && (lim_idx < NP);

    // Write-only command pulses; zero bits do nothing
    assign cmd_on   = (wr && wb_adr_i == `PPFC_REG_CMD)  ? wdat[`PPFC_LO_LSB +: NP] : {NP{1'b0}};
    assign cmd_off  = (wr && wb_adr_i == `PPFC_REG_CMD)  ? wdat[`PPFC_HI_LSB +: NP] : {NP{1'b0}};
    assign prst     = (wr && wb_adr_i == `PPFC_REG_PRST) ? wdat[`PPFC_LO_LSB +: NP] : {NP{1'b0}};
    assign clr_a_lo = (wr && wb_adr_i == `PPFC_REG_FLTA) ? wdat[`PPFC_LO_LSB +: NP] : {NP{1'b0}};
    assign clr_a_hi = (wr && wb_adr_i == `PPFC_REG_FLTA) ? wdat[`PPFC_HI_LSB +: NP] : {NP{1'b0}};
    assign clr_b    = (wr && wb_adr_i == `PPFC_REG_FLTB) ? wdat[`PPFC_LO_LSB +: NP] : {NP{1'b0}};

    ppfc_tick #(
        .DIV (TICK_CYC)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // Per-port timers and output shaping
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_port
            wire is_off;
            wire is_inr;
            wire is_on;
            wire is_fail;
            wire ovl_up;
            wire dmg;
            wire [7:0] dflt;

            assign is_off  = (st_ff[g] == `PPFC_ST_OFF);
            assign is_inr  = (st_ff[g] == `PPFC_ST_INR);
            assign is_on   = (st_ff[g] == `PPFC_ST_ON);
            assign is_fail = (st_ff[g] == `PPFC_ST_FAIL);
            assign pwr[g]  = is_inr | is_on;

            // Hard events feed the overload timer when the hard timer is off
            assign ovl_up = over_cut_i[g] | (over_lim_i[g] & ~hard_limit_timer_en_ff[g]); // RQ4 RQ10

            // Output present while off, or pin over-voltage; open switch gives none
            assign dmg = ~is_fail & ((is_off & out_present_i[g]) | sense_high_i[g] | gate_high_i[g]); // RQ16 RQ18

            // Larger resistor reads 00 as 425 mA, smaller one needs 80
            assign dflt = rsmall_ff[g] ? `PPFC_CODE_425_SML : `PPFC_CODE_425_LRG; // RQ14

            // Runs for the whole inrush period, however early charging ends
            ppfc_fault_timer #(
                .W    (17),
                .UP   (1),
                .DN   (0),
                .TERM (INR_TERM)
            ) u_inr (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .tick_i (tick),
                .clr_i  (~is_inr), // RQ2
                .up_i   (is_inr),
                .dn_i   (1'b0),
                .exp_o  (inr_exp[g])
            );

            // Up by sixteen, down by one: down rate is 1/16 of up
            ppfc_fault_timer #(
                .W    (17),
                .UP   (`PPFC_OVL_UP),
                .DN   (`PPFC_OVL_DN),
                .TERM (OVL_TERM)
            ) u_ovl (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .tick_i (tick),
                .clr_i  (~is_on), // RQ20
                .up_i   (ovl_up), // RQ4
                .dn_i   (~ovl_up), // RQ5 RQ20
                .exp_o  (ovl_exp[g])
            );

            // Restarts from zero each time the limit is left
            ppfc_fault_timer #(
                .W    (17),
                .UP   (1),
                .DN   (0),
                .TERM (HLT_TERM)
            ) u_hlt (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .tick_i (tick),
                .clr_i  (~is_on | ~hard_limit_timer_en_ff[g] | ~over_lim_i[g]), // RQ8 RQ20
                .up_i   (over_lim_i[g]),
                .dn_i   (1'b0),
                .exp_o  (hlt_exp[g])
            );

            // Condition must persist without a break to count as damage
            ppfc_fault_timer #(
                .W    (17),
                .UP   (1),
                .DN   (0),
                .TERM (DMG_TERM)
            ) u_dmg (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .tick_i (tick),
                .clr_i  (~dmg), // RQ16
                .up_i   (dmg),
                .dn_i   (1'b0),
                .exp_o  (dmg_exp[g])
            );

            assign gate_en_o[g]           = pwr[g];
            assign weak_pd_o[g]           = is_fail; // RQ16
            assign gate_lvl_o[g*GW +: GW] = lvl_ff[g];
            // Default limit in inrush and while off, programmed code once on
            assign hard_current_limit_code_o[g*8 +: 8]  = is_on ? limit_ff[g] : dflt; // RQ11

            // Stage two needs the deeper sag and a selection of two or more
            assign fold_stage_o[g*2 +: 2] =
                (volt_low2_i[g] && fold_ff[g*2 +: 2] >= 2'h2) ? 2'h2 :
                (volt_low1_i[g] && fold_ff[g*2 +: 2] != 2'h0) ? 2'h1 : 2'h0; // RQ15
        end
    endgenerate

    // Bus acknowledge and configuration writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff     <= 1'b0;
            hard_limit_timer_en_ff <= {NP{1'b0}};
            semi_ff    <= {NP{1'b0}};
            hipwr_ff   <= {NP{1'b0}};
            rsmall_ff  <= {NP{1'b0}};
            fold_ff    <= {(NP*2){1'b0}};
        end else begin
            ack_ff <= req & ~ack_ff;
            if (wr && wb_adr_i == `PPFC_REG_HARD_LIMIT_TIMER) begin
                hard_limit_timer_en_ff <= wdat[`PPFC_LO_LSB +: NP]; // RQ8
            end
            if (wr && wb_adr_i == `PPFC_REG_MODE) begin
                semi_ff  <= wdat[`PPFC_LO_LSB +: NP];
                hipwr_ff <= wdat[`PPFC_HI_LSB +: NP];
            end
            if (wr && wb_adr_i == `PPFC_REG_RSEL) begin
                rsmall_ff <= wdat[`PPFC_LO_LSB +: NP];
            end
            if (wr && wb_adr_i == `PPFC_REG_FOLD) begin
                fold_ff <= wdat[NP*2-1:0]; // RQ15
            end
        end
    end

    // Port state machines, gate ramp, limit codes and fault latches
    always @(posedge clk_i) begin
        if (rst_i) begin
            inr_flt_ff <= {NP{1'b0}};
            ovl_flt_ff <= {NP{1'b0}};
            hlt_flt_ff <= {NP{1'b0}};
            sw_fail_ff <= {NP{1'b0}};
            for (p = 0; p < NP; p = p + 1) begin
                st_ff[p]    <= `PPFC_ST_OFF;
                lvl_ff[p]   <= {GW{1'b0}};
                limit_ff[p] <= `PPFC_CODE_425_LRG;
            end
        end else begin
            // Clear by writing one; a set in the same cycle wins
            inr_flt_ff <= inr_flt_ff & ~clr_a_lo; // RQ21
            ovl_flt_ff <= ovl_flt_ff & ~clr_a_hi; // RQ21
            hlt_flt_ff <= hlt_flt_ff & ~clr_b; // RQ21
            sw_fail_ff <= sw_fail_ff & ~prst; // RQ17
            for (p = 0; p < NP; p = p + 1) begin
                if (wr && lim_hit && lim_idx == p) begin
                    limit_ff[p] <= wdat[7:0];
                end
                // Regulation loop: back off over the hard limit, hold at inrush
                if (!pwr[p]) begin
                    lvl_ff[p] <= {GW{1'b0}};
                end else if (tick && over_lim_i[p]) begin
                    if (lvl_ff[p] != {GW{1'b0}}) begin
                        lvl_ff[p] <= lvl_ff[p] - 1'b1; // RQ7
                    end
                end else if (tick && !(st_ff[p] == `PPFC_ST_INR && over_inrush_i[p])) begin
                    if (lvl_ff[p] != {GW{1'b1}}) begin
                        lvl_ff[p] <= lvl_ff[p] + 1'b1; // RQ1
                    end
                end
                if (dmg_exp[p]) begin
                    st_ff[p]      <= `PPFC_ST_FAIL; // RQ16
                    sw_fail_ff[p] <= 1'b1; // RQ16 RQ17
                    if (pwr[p]) begin
                        limit_ff[p] <= rsmall_ff[p] ? `PPFC_CODE_425_SML : `PPFC_CODE_425_LRG; // RQ12
                    end
                end else if (prst[p]) begin
                    st_ff[p] <= `PPFC_ST_OFF; // RQ17
                    if (pwr[p]) begin
                        limit_ff[p] <= rsmall_ff[p] ? `PPFC_CODE_425_SML : `PPFC_CODE_425_LRG; // RQ12
                    end
                end else begin
                    case (st_ff[p])
                        `PPFC_ST_OFF: begin
                            if (cmd_on[p]) begin
                                if (semi_ff[p] && hipwr_ff[p] && !det_good_i[p]) begin
                                    inr_flt_ff[p] <= 1'b1; // RQ19
                                end else begin
                                    st_ff[p] <= `PPFC_ST_INR; // RQ1
                                end
                            end
                        end
                        `PPFC_ST_INR: begin
                            if (cmd_off[p]) begin
                                st_ff[p]    <= `PPFC_ST_OFF;
                                limit_ff[p] <= rsmall_ff[p] ? `PPFC_CODE_425_SML : `PPFC_CODE_425_LRG; // RQ12
                            end else if (inr_exp[p]) begin
                                // No charged output means no working switch
                                if (over_inrush_i[p] || !out_good_i[p]) begin
                                    st_ff[p]      <= `PPFC_ST_OFF; // RQ3 RQ18
                                    inr_flt_ff[p] <= 1'b1; // RQ3 RQ18
                                    limit_ff[p]   <= rsmall_ff[p] ? `PPFC_CODE_425_SML : `PPFC_CODE_425_LRG; // RQ12
                                end else begin
                                    st_ff[p] <= `PPFC_ST_ON; // RQ2 RQ11
                                end
                            end
                        end
                        `PPFC_ST_ON: begin
                            if (cmd_off[p] || hlt_exp[p] || ovl_exp[p]) begin
                                st_ff[p]    <= `PPFC_ST_OFF;
                                limit_ff[p] <= rsmall_ff[p] ? `PPFC_CODE_425_SML : `PPFC_CODE_425_LRG; // RQ12
                            end
                            if (!cmd_off[p] && hlt_exp[p]) begin
                                hlt_flt_ff[p] <= 1'b1; // RQ9
                            end
                            if (!cmd_off[p] && !hlt_exp[p] && ovl_exp[p]) begin
                                ovl_flt_ff[p] <= 1'b1; // RQ6 RQ10
                            end
                        end
                        `PPFC_ST_FAIL: begin
                            st_ff[p] <= `PPFC_ST_FAIL; // RQ17
                        end
                        default: begin
                            st_ff[p] <= `PPFC_ST_OFF;
                        end
                    endcase
                end
            end
        end
    end

    // Read mux; unmapped addresses and write-only words read zero
    always @* begin
        nxt_rdat = 32'h00000000;
        case (wb_adr_i)
            `PPFC_REG_HARD_LIMIT_TIMER: nxt_rdat[`PPFC_LO_LSB +: NP] = hard_limit_timer_en_ff;
            `PPFC_REG_MODE: begin
                nxt_rdat[`PPFC_LO_LSB +: NP] = semi_ff;
                nxt_rdat[`PPFC_HI_LSB +: NP] = hipwr_ff;
            end
            `PPFC_REG_RSEL: nxt_rdat[`PPFC_LO_LSB +: NP] = rsmall_ff;
            `PPFC_REG_FOLD: nxt_rdat[NP*2-1:0] = fold_ff;
            `PPFC_REG_STAT: begin
                nxt_rdat[`PPFC_LO_LSB +: NP] = pwr;
                nxt_rdat[`PPFC_HI_LSB +: NP] = sw_fail_ff;
            end
            `PPFC_REG_FLTA: begin
                nxt_rdat[`PPFC_LO_LSB +: NP] = inr_flt_ff;
                nxt_rdat[`PPFC_HI_LSB +: NP] = ovl_flt_ff;
            end
            `PPFC_REG_FLTB: nxt_rdat[`PPFC_LO_LSB +: NP] = hlt_flt_ff;
            default: begin
                if (lim_hit) begin
                    nxt_rdat[7:0] = limit_ff[lim_idx];
                end
            end
        endcase
    end

    // Read data loaded when a request is first seen
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (req && !ack_ff) begin
            wb_dat_o <= nxt_rdat;
        end
    end

endmodule // ppfc_ctrl

// ===== dv/ppfc_ctrl_properties.sv
// Checker for port power control, bound to ppfc_ctrl
`timescale 1ns/1ps
module ppfc_chk #(
    parameter NP = 12,
    parameter GW = 4
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_ack_o,
    input wire logic [NP-1:0]    sense_high_i,
    input wire logic [NP-1:0]    volt_low1_i,
    input wire logic [NP-1:0]    volt_low2_i,
    input wire logic [NP-1:0]    gate_en_o,
    input wire logic [NP*GW-1:0] gate_lvl_o,
    input wire logic [NP*8-1:0]  hard_current_limit_code_o,
    input wire logic [NP*2-1:0]  fold_stage_o,
    input wire logic [NP-1:0]    weak_pd_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reg [5:0] dmg_ff;
    // Unbroken damage cycles on port 1
    always @(posedge clk_i) begin
        if (rst_i || !sense_high_i[1] || weak_pd_o[1]) dmg_ff <= 6'h00;
        else if (dmg_ff != 6'h3F) dmg_ff <= dmg_ff + 6'h01;
    end
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_off_dflt; !gate_en_o[0] |-> hard_current_limit_code_o[7:0] == 8'h00; endproperty
    a_off_dflt: assert property (p_off_dflt) else $error("limit not default");
    property p_inr_dflt; $rose(gate_en_o[0]) |-> (hard_current_limit_code_o[7:0] == 8'h00) [*8]; endproperty
    a_inr_dflt: assert property (p_inr_dflt) else $error("inrush limit");
    property p_ramp; gate_en_o[0] |-> gate_lvl_o[3:0] <= $past(gate_lvl_o[3:0]) + 5'h01; endproperty
    a_ramp: assert property (p_ramp) else $error("gate jumped");
    property p_off_gate; !gate_en_o[0] ##1 !gate_en_o[0] |-> gate_lvl_o[3:0] == 4'h0; endproperty
    a_off_gate: assert property (p_off_gate) else $error("gate driven while off");
    property p_fail_off; weak_pd_o[1] |-> !gate_en_o[1]; endproperty
    a_fail_off: assert property (p_fail_off) else $error("failed port powered");
    property p_dmg_time; dmg_ff < 6'h18; endproperty
    a_dmg_time: assert property (p_dmg_time) else $error("damage ignored");
    property p_fold; fold_stage_o[1:0] != 2'h0 |-> volt_low1_i[0] || volt_low2_i[0]; endproperty
    a_fold: assert property (p_fold) else $error("stray foldback");
    c_fail: cover property ($rose(weak_pd_o[1]));
    c_on: cover property ($rose(gate_en_o[0]));
    c_off: cover property ($fell(gate_en_o[0]));
endmodule // ppfc_chk

bind ppfc_ctrl ppfc_chk #(.NP(NP), .GW(GW)) u_chk (.*);

// ===== dv/ppfc_far_side.sv
// Switch, sense resistor and load model per port
`timescale 1ns/1ps
module ppfc_far_side #(
    parameter NP = 12
) (
    input  wire logic          clk_i,
    input  wire logic [NP-1:0] gate_en_i,
    input  wire logic [NP-1:0] open_i,
    input  wire logic [NP-1:0] hvy_i,
    input  wire logic          slow_i,
    input  wire logic [NP-1:0] cut_i,
    input  wire logic [NP-1:0] lim_i,
    input  wire logic [NP-1:0] dmg_i,
    output wire logic [NP-1:0] over_inrush_o,
    output wire logic [NP-1:0] over_cut_o,
    output wire logic [NP-1:0] over_lim_o,
    output wire logic [NP-1:0] out_good_o,
    output wire logic [NP-1:0] out_present_o,
    output wire logic [NP-1:0] sense_high_o,
    output wire logic [NP-1:0] gate_high_o
);
    reg  [NP-1:0] chg1_ff;
    reg  [NP-1:0] chg2_ff;
    wire [NP-1:0] done;
    // Output charges one or two cycles after gate on
    always @(posedge clk_i) begin
        chg1_ff <= gate_en_i;
        chg2_ff <= chg1_ff & gate_en_i;
    end
    // Open switch: no charge, no current
    assign done          = (slow_i ? chg2_ff : chg1_ff) & gate_en_i & ~open_i & ~hvy_i;
    assign over_inrush_o = gate_en_i & ~open_i & (~done | hvy_i);
    // Current at the hard limit also exceeds the cut level
    assign over_cut_o    = gate_en_i & (cut_i | lim_i);
    assign over_lim_o    = gate_en_i & lim_i;
    assign out_good_o    = done;
    assign out_present_o = gate_en_i & ~open_i;
    assign sense_high_o  = dmg_i;
    assign gate_high_o   = {NP{1'b0}};
endmodule // ppfc_far_side

// ===== dv/ppfc_ctrl_bench.sv
// Self-checking bench of port power control
`timescale 1ns/1ps
`include "ppfc_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ppfc_ctrl_bench;
    logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, slow = 0;
    logic [7:0]  adr = 0;
    logic [31:0] wd = 0, r, t;
    logic [11:0] opn = 0, hvy = 0, cut = 0, lim = 0, dmg = 0, det = 0, vl1 = 0, vl2 = 0;
    wire  [31:0] rd;
    wire         ack;
    wire  [11:0] oi, oc, ol, og, op, sh, gh, gen, wpd;
    wire  [47:0] glvl;
    wire  [95:0] code;
    wire  [23:0] fold;
    integer      fail_count = 0, checked = 0, seed = 29014, i, p, s, m_pwr, m_a, m_b, m_f, m_fo;
    integer      m_lim [0:11];
    ppfc_ctrl #(.TICK_CYC(4), .OVL_TERM(160), .HLT_TERM(8), .INR_TERM(8), .DMG_TERM(3)) uut (
        .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .over_inrush_i(oi), .over_cut_i(oc),
        .over_lim_i(ol), .out_good_i(og), .out_present_i(op), .sense_high_i(sh), .gate_high_i(gh),
        .det_good_i(det), .volt_low1_i(vl1), .volt_low2_i(vl2), .gate_en_o(gen), .gate_lvl_o(glvl),
        .hard_current_limit_code_o(code), .fold_stage_o(fold), .weak_pd_o(wpd));
    ppfc_far_side far (.clk_i, .gate_en_i(gen), .open_i(opn), .hvy_i(hvy), .slow_i(slow),
        .cut_i(cut), .lim_i(lim), .dmg_i(dmg), .over_inrush_o(oi), .over_cut_o(oc), .over_lim_o(ol),
        .out_good_o(og), .out_present_o(op), .sense_high_o(sh), .gate_high_o(gh));
    // 125 MHz clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task finish_test;
        begin
            if (fail_count == 0 && checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Classic single cycle; read data taken at the ack edge only
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            cyc <= 1'b1; we <= w; adr <= a; wd <= d;
            n = 0;
            do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
            if (n >= 20) begin fail_count++; $display("[FAIL] %0t bus hang", $time); finish_test; end
            r = rd;
            cyc <= 1'b0; we <= 1'b0;
        end
    endtask
    task wait_cyc(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    // Compare status and outputs with the model
    task chk_all;
        begin
            wb(0, `PPFC_REG_STAT, 0); `CHK(r, (m_f << 16) | m_pwr)
            wb(0, `PPFC_REG_FLTA, 0); `CHK(r, m_a)
            wb(0, `PPFC_REG_FLTB, 0); `CHK(r, m_b)
            `CHK(gen, m_pwr[11:0])
            `CHK(wpd, m_f[11:0])
            for (p = 0; p < 12; p++) `CHK(code[p*8 +: 8], m_pwr[p] ? m_lim[p][7:0] : (p == 2 ? 8'h80 : 8'h00))
        end
    endtask
    initial begin
        wait_cyc(16);
        rst_i <= 1'b0;
        m_pwr = 0; m_a = 0; m_b = 0; m_f = 0;
        // Reset values, unmapped holes included
        for (i = 0; i < 16; i++) begin wb(0, 8'(8 + 4 * i), 0); `CHK(r, 32'h0) end
        wb(1, `PPFC_REG_RSEL, 32'h4);
        wb(1, `PPFC_REG_HARD_LIMIT_TIMER, 32'h40);
        wb(0, `PPFC_REG_HARD_LIMIT_TIMER, 0); `CHK(r, 32'h40)
        m_fo = $random(seed) & 32'hFFFFFF;
        wb(1, `PPFC_REG_FOLD, m_fo);
        wb(0, `PPFC_REG_FOLD, 0); `CHK(r, m_fo)
        for (p = 0; p < 12; p++) begin m_lim[p] = $random(seed) & 32'hFF; wb(1, 8'(64 + 4 * p), m_lim[p]); end
        // Random voltages; stage 2 implies stage 1
        for (i = 0; i < 4; i++) begin
            t = $random(seed);
            vl2 <= t[11:0]; vl1 <= t[11:0] | t[27:16];
            wait_cyc(2);
            for (p = 0; p < 12; p++) begin
                s = (m_fo >> (2 * p)) & 3;
                `CHK(fold[2*p +: 2], 2'((s == 0) ? 0 : (s > 1 && vl2[p]) ? 2 : vl1[p]))
            end
        end
        // All on: open switch, stuck inrush, semi-auto, bad detect
        wb(1, `PPFC_REG_MODE, 32'h0020_0020);
        opn <= 12'h008; hvy <= 12'h010; slow <= 1'b1;
        wb(1, `PPFC_REG_CMD, 32'hFFF);
        wait_cyc(80);
        m_pwr = 32'hFC7; m_a = 32'h38;
        chk_all;
        // Sparse short overloads are forgiven
        for (i = 0; i < 5; i++) begin cut[0] <= 1'b1; wait_cyc(8); cut[0] <= 1'b0; wait_cyc(200); end
        chk_all;
        cut[0] <= 1'b1; lim[6] <= 1'b1; lim[8] <= 1'b1;
        wait_cyc(100);
        cut <= 0; lim <= 0;
        m_pwr &= ~32'h141; m_a |= 32'h0101_0000; m_b = 32'h40;
        chk_all;
        wb(0, `PPFC_REG_LIM0, 0); `CHK(r, 32'h0)
        wb(1, `PPFC_REG_CMD, 32'h0080_0000);
        m_pwr &= ~32'h80;
        chk_all;
        // Damage on port 1 outlives a port reset
        dmg[1] <= 1'b1; wait_cyc(40);
        m_pwr &= ~32'h2; m_f = 2;
        chk_all;
        wb(1, `PPFC_REG_PRST, 32'h2); wait_cyc(40);
        chk_all;
        dmg[1] <= 1'b0;
        wb(1, `PPFC_REG_PRST, 32'h2); wait_cyc(5);
        m_f = 0;
        chk_all;
        wb(1, `PPFC_REG_FLTA, 32'h38);
        wb(1, `PPFC_REG_STAT, 32'hFFFFFFFF);
        m_a &= ~32'h38;
        chk_all;
        // Repower port 0 with a new limit
        wb(1, `PPFC_REG_LIM0, 32'h40); m_lim[0] = 32'h40;
        slow <= 1'b0;
        wb(1, `PPFC_REG_CMD, 32'h1); wait_cyc(80);
        m_pwr |= 1;
        chk_all;
        wb(0, `PPFC_REG_CMD, 0); `CHK(r, 32'h0)
        finish_test;
    end
    // Hang guard
    initial begin
        wait_cyc(20000);
        fail_count++;
        finish_test;
    end
endmodule // ppfc_ctrl_bench
